//--- src/retry_pkg.sv
// Purpose: Shared constants and types for the fault restart retry controller
// Assumes: 32-bit APB, word-aligned registers
// Notes:   Offsets are byte addresses
package retry_pkg;
	localparam logic [7:0] off_resp      = 8'h00;
	localparam logic [7:0] off_unit      = 8'h04;
	localparam logic [7:0] off_ctrl      = 8'h08;
	localparam logic [7:0] off_state     = 8'h0c;
	localparam logic [7:0] off_irq_stat  = 8'h10;
	localparam logic [7:0] off_irq_en    = 8'h14;
	localparam logic [7:0] off_irq_clr   = 8'h18;
	localparam int         retry_lsb     = 3;
	localparam int         delay_lsb     = 0;
	localparam logic [2:0] retry_none    = 3'h0;
	localparam logic [2:0] retry_forever = 3'h7;
	localparam logic [7:0] resp_reset    = 8'h00;
	localparam logic [15:0] unit_reset   = 16'h0019;
	localparam int         clk_mhz       = 25;
	localparam int         unit_us       = 1;
	localparam int         unit_cycles   = (unit_us * clk_mhz < 1) ? 1 : unit_us * clk_mhz;
	localparam int         ev_shutdown   = 0;
	localparam int         ev_restart    = 1;
	localparam int         ev_latched    = 2;
	localparam int         ev_cleared    = 3;
	localparam int         n_events      = 4;

	typedef enum logic [2:0] {
		st_run     = 3'b000,
		st_grace   = 3'b001,
		st_wait    = 3'b010,
		st_attempt = 3'b011,
		st_latched = 3'b100
	} seq_e;

	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] retries;
		logic [2:0] delay;
	} resp_s;

	typedef struct packed {
		logic [2:0] state;
		logic [2:0] left;
		logic       out_en;
		logic       latched;
	} stat_s;
endpackage

//--- src/delay_timer.sv
// Purpose: Counts delay time units as powers of two
// Assumes: Unit length given in pclk cycles
// Notes:   Once started, rearms itself after every interval; start realigns it
`timescale 1ns/100ps
module delay_timer
	import retry_pkg::*;
#(
	parameter int unit_w = 16
)(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              start,
	input  wire logic [2:0]        code,
	input  wire logic [unit_w-1:0] unit_len,
	output logic                   done
);
	logic [unit_w-1:0] cyc;
	logic [7:0]        units;
	logic              busy;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cyc   <= '0;
			units <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				cyc   <= '0;
				units <= 8'(8'h01 << code) - 8'h01; // RQ5
				busy  <= 1'b1;
			end
			else if (busy)
			begin
				if (cyc >= unit_len - unit_w'(1) || unit_len == '0) // RQ7
				begin
					cyc <= '0;
					if (units == 8'h00)
					begin
						// Rearm on the same edge so intervals stay exactly back to back
						units <= 8'(8'h01 << code) - 8'h01; // RQ5
						done  <= 1'b1;
					end
					else
						units <= units - 8'h01;
				end
				else
					cyc <= cyc + unit_w'(1);
			end
		end
	end
endmodule // delay_timer

//--- src/fault_restart_retry_control.sv
// Purpose: Sequences restart attempts after a fault, latches off when exhausted
// Assumes: fault_in, off_cmd, restart_ok are pins, synchronised here
// Notes:   Registers over APB; delay = 2^code units, unit from unit register
// Function
// RQ1: Codes three to six give exactly that many restart attempts.
// RQ2: Output stays off after all attempts fail, until cleared.
// RQ3: Code seven retries forever until commanded off or another fault.
// RQ4: Attempts spaced start to start by delay count times time unit.
// RQ5: Delay code n means two to the n time units.
// RQ6: Same delay is the grace time in delayed-response mode.
// RQ7: Unit length comes from a separate time-unit register.
// RQ8: Retry count lives in bits five to three of the response byte.
// RQ9: Zero retry count means no attempt, output held off.
// RQ10: Clear by status bit, clear-all, or output off then on. No status-bit clear here; only the control clear bit or off then on.
// RQ11: Fault clearing reloads attempt counter and delay timer.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
module fault_restart_retry_control
	import retry_pkg::*;
#(
	parameter int unit_w = 16
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        fault_in,
	input  wire logic        other_fault,
	input  wire logic        off_cmd,
	input  wire logic        restart_ok,
	output logic             out_en,
	output logic             irq
);
	resp_s             resp;
	logic [unit_w-1:0] unit_len;
	logic              op_on;
	logic [n_events-1:0] irq_stat, irq_en, ev;
	logic [1:0]        s_fault, s_other, s_off, s_ok;
	logic              fault, other, pin_off, ok, cmd_off_prev, clear_req;
	seq_e              state;
	logic [2:0]        left;
	logic              tstart, tdone, tick;
	logic              wr, rd;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	// A done pulse from the interval just left is dropped while the timer rearms
	assign tick = tdone && !tstart;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// Two-stage synchronisers for pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_fault <= '0;
			s_other <= '0;
			s_off   <= '0;
			s_ok    <= '0;
		end
		else
		begin
			s_fault <= {s_fault[0], fault_in};
			s_other <= {s_other[0], other_fault};
			s_off   <= {s_off[0], off_cmd};
			s_ok    <= {s_ok[0], restart_ok};
		end
	end
	assign fault   = s_fault[1];
	assign other   = s_other[1];
	assign pin_off = s_off[1] || !op_on;
	assign ok      = s_ok[1];

	// Register writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resp     <= resp_s'(resp_reset);
			unit_len <= unit_w'(unit_cycles);
			op_on    <= 1'b1;
		end
		else if (wr)
		begin
			if (hit(paddr, off_resp))
				resp <= resp_s'(pwdata[7:0]); // RQ8
			if (hit(paddr, off_unit))
				unit_len <= pwdata[unit_w-1:0]; // RQ7
			if (hit(paddr, off_ctrl))
				op_on <= pwdata[0];
		end
	end

	// Clear requests: clear-all bit in the control register, or off-then-on edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_off_prev <= 1'b0;
			clear_req    <= 1'b0;
		end
		else
		begin
			cmd_off_prev <= pin_off;
			clear_req    <= (wr && hit(paddr, off_ctrl) && pwdata[1])
				|| (cmd_off_prev && !pin_off); // RQ10
		end
	end

	// Retry sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state  <= st_run;
			left   <= '0;
			out_en <= 1'b1;
			tstart <= 1'b0;
			ev     <= '0;
		end
		else
		begin
			tstart <= 1'b0;
			ev     <= '0;
			if (clear_req && !pin_off)
			begin
				state  <= st_run; // RQ11
				left   <= resp.retries;
				out_en <= 1'b1;
				ev[ev_cleared] <= 1'b1;
			end
			else if (pin_off)
			begin
				out_en <= 1'b0; // RQ3
				if (state != st_latched)
					state <= st_run;
			end
			else
			begin
				unique case (state)
					st_run:
					begin
						out_en <= 1'b1;
						left   <= resp.retries; // RQ8
						if (fault)
						begin
							tstart <= 1'b1;
							if (resp.mode == 2'b01)
								state <= st_grace; // RQ6
							else
							begin
								out_en <= 1'b0;
								ev[ev_shutdown] <= 1'b1;
								if (resp.retries == retry_none)
								begin
									state <= st_latched; // RQ9
									ev[ev_latched] <= 1'b1;
								end
								else
									state <= st_wait;
							end
						end
					end
					st_grace:
						if (tick)
						begin
							out_en <= !fault;
							ev[ev_shutdown] <= fault;
							if (!fault)
								state <= st_run;
							else if (resp.retries == retry_none)
							begin
								state <= st_latched; // RQ9
								ev[ev_latched] <= 1'b1;
							end
							else
							begin
								state  <= st_wait;
								tstart <= 1'b1;
							end
						end
					st_wait:
						if (tick)
						begin
							// Output rises next cycle, from the attempt state
							state  <= st_attempt; // RQ4
							ev[ev_restart] <= 1'b1;
							if (resp.retries != retry_forever)
								left <= left - 3'h1; // RQ1
						end
					st_attempt:
						if (other)
						begin
							out_en <= 1'b0; // RQ3
							state  <= st_latched;
							ev[ev_latched] <= 1'b1;
						end
						else if (ok && !fault)
							state <= st_run;
						else if (tick)
						begin
							// Failed attempt drops the output one cycle; needs intervals of 2+
							out_en <= 1'b0;
							if (left == 3'h0 && resp.retries != retry_forever)
							begin
								state  <= st_latched; // RQ2
								ev[ev_latched] <= 1'b1;
							end
							else
							begin
								ev[ev_restart] <= 1'b1; // RQ4
								if (resp.retries != retry_forever)
									left <= left - 3'h1; // RQ1
							end
						end
						else
							out_en <= 1'b1;
					st_latched:
						out_en <= 1'b0; // RQ2
					default:
						state <= st_latched;
				endcase
			end
		end
	end

	delay_timer #(
		.unit_w   (unit_w)
	) u_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (tstart),
		.code     (resp.delay),
		.unit_len (unit_len),
		.done     (tdone)
	);

	// Interrupt status: set wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat <= '0;
			irq_en   <= '0;
			irq      <= 1'b0;
		end
		else
		begin
			if (wr && hit(paddr, off_irq_en))
				irq_en <= pwdata[n_events-1:0];
			if (wr && hit(paddr, off_irq_clr))
				irq_stat <= (irq_stat & ~pwdata[n_events-1:0]) | ev;
			else
				irq_stat <= irq_stat | ev;
			irq <= |(irq_stat & irq_en);
		end
	end

	// APB read path, zero wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable && !pwrite)
			begin
				unique case (paddr)
					off_resp:     prdata <= {24'h0, resp};
					off_unit:     prdata <= 32'(unit_len);
					off_ctrl:     prdata <= {31'h0, op_on};
					off_state:    prdata <= {24'h0, stat_s'({state, left, out_en,
						state == st_latched})};
					off_irq_stat: prdata <= 32'(irq_stat);
					off_irq_en:   prdata <= 32'(irq_en);
					default:      prdata <= 32'h0;
				endcase
			end
			if (psel && !penable && !(hit(paddr, off_resp) || hit(paddr, off_unit)
				|| hit(paddr, off_ctrl) || hit(paddr, off_state)
				|| hit(paddr, off_irq_stat) || hit(paddr, off_irq_en)
				|| hit(paddr, off_irq_clr)))
				pslverr <= 1'b1;
		end
	end

	logic [2:0] attempts_seen;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			attempts_seen <= '0;
		else if (state == st_run)
			attempts_seen <= '0;
		else if (ev[ev_restart] && attempts_seen != 3'h7)
			attempts_seen <= attempts_seen + 3'h1;
	end

	no_retry_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
		state == st_run && fault && !pin_off && !clear_req && resp.mode != 2'b01
		&& resp.retries == retry_none |=> state == st_latched && !out_en)
		else $error("zero retry did not latch off");
	latched_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		state == st_latched && !clear_req |=> !out_en)
		else $error("output on while latched");
	count_limit_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		resp.retries != retry_forever && state != st_run
		|-> attempts_seen <= resp.retries)
		else $error("too many restart attempts");
	forever_no_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		state == st_attempt && tdone && resp.retries == retry_forever && !other
		&& !pin_off && !clear_req && !(ok && !fault) |=> state == st_attempt)
		else $error("continuous retry stopped");
	restart_timer_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		ev[ev_restart] |-> $past(tdone))
		else $error("restart not on timer expiry");
	clear_reload_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
		clear_req && !pin_off |=> state == st_run && left == $past(resp.retries))
		else $error("clear did not reload");
	off_cmd_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
		pin_off && !clear_req |=> !out_en)
		else $error("output on while commanded off");
	grace_on_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		state == st_grace && !tdone && !pin_off |=> out_en)
		else $error("output off during grace time");

	latch_c: cover property (@(posedge pclk) state == st_attempt ##1 state == st_latched);
	retry_c: cover property (@(posedge pclk) ev[ev_restart] ##[1:1000] ev[ev_restart]);
	clear_c: cover property (@(posedge pclk) state == st_latched ##1 clear_req);
	grace_c: cover property (@(posedge pclk) state == st_grace ##1 state == st_wait);
endmodule // fault_restart_retry_control

//--- bench/host_model.sv
// Purpose: Host side model that writes and reads the settings over APB
// Assumes: Slave may insert wait states; the wait is bounded here
// Notes:   Write data turns over once released, so stale data is never read
`timescale 1ns/100ps
module host_model(
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// Request held until pready is sampled high or 50 access cycles pass
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output logic ok);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		ok = (pready === 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		// One idle edge so the next setup never lands in this time step
		@(posedge pclk);
	endtask
endmodule // host_model

//--- bench/fault_restart_retry_control_test.sv
// Purpose: Self-checking bench for the fault restart retry controller
// Assumes: Level pins pass a two-stage synchroniser
// Notes:   Restart attempts are counted as rising edges of out_en
`timescale 1ns/100ps
module fault_restart_retry_control_test;
	import retry_pkg::*;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        fault_in = 0;
	logic        other_fault = 0;
	logic        off_cmd = 0;
	logic        restart_ok = 0;
	logic        psel, penable, pwrite, pready, pslverr, out_en, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	int          miscompares = 0;
	int          check_count = 0;
	int          unit, att, ie, t;
	int          gq[$];

	always #20 pclk = ~pclk;

	fault_restart_retry_control u_fault_restart_retry_control(.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_in,
		.other_fault, .off_cmd, .restart_ok, .out_en, .irq);
	host_model u_host(.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
		logic e, ok;
		u_host.xfer(w, a, d, r, e, ok);
		cmp("pready", 1, ok);
		cmp("pslverr", er, e);
		if (ok !== 1'b1)
			summarize();
	endtask

	// Watches n cycles; start-to-start gaps go to the queue and are checked
	task automatic watch(input int d, input int n);
		logic p;
		int last;
		att = 0;
		last = -1;
		p = out_en;
		for (int i = 0; i < n; i++)
		begin
			@(posedge pclk);
			if (out_en === 1'b1 && p === 1'b0)
			begin
				if (last >= 0)
					gq.push_back(i - last);
				last = i;
				att++;
			end
			p = out_en;
		end
		while (gq.size() > 0)
			cmp("gap", (1 << d) * unit, gq.pop_front());
	endtask

	task automatic clr;
		fault_in <= 1'b0;
		other_fault <= 1'b0;
		acc(1, off_ctrl, 3, 0);
	endtask

	// Shutdown mode fault, then clear by a rotating method
	task automatic trial(input int c, input int d, input int how);
		acc(1, off_resp, {24'h0, 2'b10, c[2:0], d[2:0]}, 0);
		fault_in <= 1'b1;
		watch(d, (c + 2) * 2 * (1 << d) * unit + 40);
		cmp("attempts", c, att);
		cmp("out_en off", 0, out_en);
		acc(0, off_state, 0, 0);
		cmp("latched", 1, r[0]);
		acc(0, off_irq_stat, 0, 0);
		cmp("stat latched", 1, r[2]);
		cmp("irq", ie, irq);
		fault_in <= 1'b0;
		if (how == 0)
			acc(1, off_ctrl, 3, 0);
		else if (how == 1)
		begin
			acc(1, off_ctrl, 0, 0);
			acc(1, off_ctrl, 1, 0);
		end
		else
		begin
			off_cmd <= 1'b1;
			repeat (8) @(posedge pclk);
			off_cmd <= 1'b0;
		end
		repeat (8) @(posedge pclk);
		acc(0, off_state, 0, 0);
		cmp("cleared", 0, r[0]);
		cmp("out_en on", 1, out_en);
		acc(1, off_irq_clr, 32'hf, 0);
		repeat (2) @(posedge pclk);
		cmp("irq clr", 0, irq);
	endtask

	initial
	begin
		#4000000;
		miscompares++;
		summarize();
	end

	initial
	begin
		att = $urandom(91);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		acc(0, off_resp, 0, 0);
		cmp("resp reset", resp_reset, r);
		acc(0, off_unit, 0, 0);
		cmp("unit reset", unit_reset, r);
		acc(0, off_ctrl, 0, 0);
		cmp("ctrl reset", 1, r);
		acc(0, 8'hfc, 0, 1);
		cmp("unmapped", 0, r);
		// Two cycles or more, so the shortest interval still shows the off pulse
		unit = 2 + $urandom % 3;
		acc(1, off_unit, unit, 0);
		acc(0, off_unit, 0, 0);
		cmp("unit", unit, r);
		acc(1, off_irq_en, 4, 0);
		ie = 1;
		for (int c = 0; c < 7; c++)
			trial(c, 1, c % 3);
		// Latched interrupt masked for the delay sweep
		acc(1, off_irq_en, 0, 0);
		ie = 0;
		for (int d = 0; d < 8; d++)
			trial(2, d, 0);
		acc(1, off_resp, {24'h0, 2'b10, 3'h7, 3'h1}, 0);
		fault_in <= 1'b1;
		watch(1, 200);
		cmp("forever", 1, att > 8);
		other_fault <= 1'b1;
		repeat (10) @(posedge pclk);
		watch(1, 100);
		cmp("stopped", 0, att);
		clr();
		acc(1, off_resp, {24'h0, 2'b01, 3'h0, 3'h4}, 0);
		fault_in <= 1'b1;
		t = 0;
		while (out_en === 1'b1 && t < 2000)
		begin
			@(posedge pclk);
			t++;
		end
		cmp("grace min", 1, t >= 16 * unit);
		cmp("grace max", 1, t <= 16 * unit + 8);
		clr();
		acc(1, off_resp, {24'h0, 2'b10, 3'h3, 3'h3}, 0);
		fault_in <= 1'b1;
		repeat (8) @(posedge pclk);
		t = 0;
		while (out_en !== 1'b1 && t < 500)
		begin
			@(posedge pclk);
			t++;
		end
		fault_in <= 1'b0;
		restart_ok <= 1'b1;
		repeat (40) @(posedge pclk);
		cmp("restart held", 1, out_en);
		acc(0, off_state, 0, 0);
		cmp("state run", st_run, r[7:5]);
		restart_ok <= 1'b0;
		summarize();
	end
endmodule // fault_restart_retry_control_test
